// file: hdl/das_seq.sv
// Activation sequencer for a master or slave line transceiver.
// Assumes line detectors and training logic drive i_line, and that
// i_bit_en pulses once per line bit, synchronous to i_clk.
`include "das_defines.svh"
`default_nettype none
// Functional notes
// - Master starts from idle on request, sends two-level
// - Master steps by timer, waits for slave signal
// - Idle slave hearing master starts timer, waits
// - Slave silent until timer passes second threshold
// - Master reloads timer to threshold two plus one
// - Late slave: master waits until signal or expiry
// - After fifth timer, four-level progress is data driven
// - Sub-state durations programmable, documented defaults
// - Unframed modes go straight Active and stay
// - Framed modes search sync word, two hits
// - Active1 until timer expiry, then Active2
// - Expiry or signal loss before Active1 deactivates
// - Master leaves on loss timer, slave on silence
// - Timer is multiplier times frame length bits
// - Bits 6:5 choose multiplier, one code reserved
// - Master loss timer clears while signal present
// - Six missed words start deactivation timer
// - Default deactivation and loss durations
// - Pending deactivation from Active1 or Active2
// - Expired attempt returns straight to Inactive
// - Four-bit sub-state status with fixed codes
// - Received data held high until Active1
module das_seq #(
  parameter int unsigned INC_BITS = `DAS_INC_BITS,
  parameter int unsigned DEACT_CYC = `DAS_DEACT_MS * 1000 * `DAS_CLK_MHZ,
  parameter int unsigned LOS_CYC = `DAS_LOS_MS * 1000 * `DAS_CLK_MHZ,
  parameter logic [7:0] M_SUBSTATE_TIMER_ONE = `DAS_M_SUBSTATE_TIMER_ONE,
  parameter logic [7:0] M_SUBSTATE_TIMER_TWO = `DAS_M_SUBSTATE_TIMER_TWO,
  parameter logic [7:0] M_SUBSTATE_TIMER_THREE = `DAS_M_SUBSTATE_TIMER_THREE,
  parameter logic [7:0] M_SUBSTATE_TIMER_FOUR = `DAS_M_SUBSTATE_TIMER_FOUR,
  parameter logic [7:0] M_SUBSTATE_TIMER_FIVE = `DAS_M_SUBSTATE_TIMER_FIVE,
  parameter logic [7:0] S_SUBSTATE_TIMER_ONE = `DAS_S_SUBSTATE_TIMER_ONE,
  parameter logic [7:0] S_SUBSTATE_TIMER_TWO = `DAS_S_SUBSTATE_TIMER_TWO,
  parameter logic [7:0] S_SUBSTATE_TIMER_THREE = `DAS_S_SUBSTATE_TIMER_THREE,
  parameter logic [7:0] S_SUBSTATE_TIMER_FOUR = `DAS_S_SUBSTATE_TIMER_FOUR,
  parameter logic [7:0] S_SUBSTATE_TIMER_FIVE = `DAS_S_SUBSTATE_TIMER_FIVE,
  parameter logic [25:0] ACTIVATION_TIMER_MULTIPLIER_0 = `DAS_ACTIVATION_TIMER_MULTIPLIER_0,
  parameter logic [25:0] ACTIVATION_TIMER_MULTIPLIER_1 = `DAS_ACTIVATION_TIMER_MULTIPLIER_1,
  parameter logic [25:0] ACTIVATION_TIMER_MULTIPLIER_2 = `DAS_ACTIVATION_TIMER_MULTIPLIER_2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_bit_en,
  input wire das_pkg::das_cfg_t i_cfg,
  input wire das_pkg::das_line_t i_line,
  input wire logic i_rx_data,
  output das_pkg::das_stat_t o_stat,
  output logic o_rx_data
);
  // ****************************************
  // Declarations
  // ****************************************
  das_pkg::das_state_t state_r;
  das_pkg::das_state_t state_nxt;
  logic [3:0] sub_r;
  logic [3:0] sub_nxt;
  logic [7:0] inc_r;
  logic fail_r;
  logic [25:0] fl;
  logic [25:0] activation_timer_multiplier;
  logic [25:0] mat_limit;
  logic mat_exp;
  logic inc_done;
  logic frame_done;
  logic deact_exp;
  logic los_exp;
  logic fsw_locked;
  logic fsw_lost;
  logic framed;
  logic master;
  logic resync;
  logic aborting;
  logic [7:0] t1, t2, t3, t4, t5;

  assign master = i_cfg.master;
  assign framed = i_cfg.mode[2] & i_cfg.mode[1];
  // Per-role sub-state thresholds
  assign t1 = master ? M_SUBSTATE_TIMER_ONE : S_SUBSTATE_TIMER_ONE;
  assign t2 = master ? M_SUBSTATE_TIMER_TWO : S_SUBSTATE_TIMER_TWO;
  assign t3 = master ? M_SUBSTATE_TIMER_THREE : S_SUBSTATE_TIMER_THREE;
  assign t4 = master ? M_SUBSTATE_TIMER_FOUR : S_SUBSTATE_TIMER_FOUR;
  assign t5 = master ? M_SUBSTATE_TIMER_FIVE : S_SUBSTATE_TIMER_FIVE;

  // ****************************************
  // Timers
  // ****************************************
  // Frame length and multiplier; reserved code falls back to the first
  assign fl = (i_cfg.mode == `DAS_MODE6) ? `DAS_FL_M6 : `DAS_FL_STD;
  always_comb begin
    case (i_cfg.activation_timer_multiplier_sel)
      2'b01: activation_timer_multiplier = ACTIVATION_TIMER_MULTIPLIER_1;
      2'b10: activation_timer_multiplier = ACTIVATION_TIMER_MULTIPLIER_2;
      default: activation_timer_multiplier = ACTIVATION_TIMER_MULTIPLIER_0;
    endcase
  end
  // Timer limit in bits: multiplier times frame length
  always_comb begin
    mat_limit = 26'(activation_timer_multiplier * fl);
  end

  // Activation timer runs from the start of an attempt to expiry
  das_count #(.W(26)) u_mat (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(state_r == das_pkg::DAS_INACTIVE),
    .i_en(i_bit_en),
    .i_limit(mat_limit),
    .o_done(mat_exp)
  );
  // Increment divider; self-clears so each wrap is one pulse
  das_count #(.W(32)) u_inc (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(inc_done || resync || state_r == das_pkg::DAS_INACTIVE),
    .i_en(i_bit_en),
    .i_limit(INC_BITS),
    .o_done(inc_done)
  );
  // Frame divider paces the sync word checks
  das_count #(.W(26)) u_frame (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(frame_done),
    .i_en(i_bit_en),
    .i_limit(fl - 26'd1),
    .o_done(frame_done)
  );
  // Deactivation timer runs only while pending
  das_count #(.W(32)) u_deact (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(state_r != das_pkg::DAS_PEND_DEACT),
    .i_en(1'b1),
    .i_limit(DEACT_CYC),
    .o_done(deact_exp)
  );
  // Loss timer: master only, cleared whenever signal is heard
  das_count #(.W(32)) u_los (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(!master || i_line.sig_det ||
           state_r != das_pkg::DAS_DEACTIVATED),
    .i_en(1'b1),
    .i_limit(LOS_CYC),
    .o_done(los_exp)
  );
  // Sync word tracking in frame search and the active states
  das_fsw_track u_fsw (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(framed && (sub_r == `DAS_SUB_FRAME || (!master && sub_r == `DAS_SUB_4LVL) ||
           state_r != das_pkg::DAS_ACTIVATING)),
    .i_frame_tick(frame_done),
    .i_hit(i_line.fsw_hit),
    .o_locked(fsw_locked),
    .o_lost(fsw_lost)
  );

  // Substate timer: cleared idle, reloaded on resync
  assign resync = master && state_r == das_pkg::DAS_ACTIVATING &&
                  sub_r == `DAS_SUB_SIGWAIT && i_line.s0_det;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      inc_r <= '0;
    end else if (state_r == das_pkg::DAS_INACTIVE) begin
      inc_r <= '0;
    end else if (resync) begin
      inc_r <= t2 + 8'd1;
    end else if (inc_done && inc_r != 8'hff) begin
      inc_r <= inc_r + 8'd1;
    end
  end

  // ****************************************
  // Activation state machine
  // ****************************************
  // Abort before Active1: expiry, or line silent once it should be heard
  assign aborting = mat_exp ||
    (!i_line.sig_det && (!master || sub_r >= `DAS_SUB_4));

  always_comb begin
    state_nxt = state_r;
    sub_nxt = sub_r;
    case (state_r)
      das_pkg::DAS_INACTIVE: begin
        if (!i_cfg.quiet && master && i_cfg.act_req) begin
          state_nxt = das_pkg::DAS_ACTIVATING;
          sub_nxt = `DAS_SUB_1;
        end else if (!i_cfg.quiet && !master && i_line.sig_det) begin
          state_nxt = das_pkg::DAS_ACTIVATING;
          sub_nxt = `DAS_SUB_1;
        end
      end
      das_pkg::DAS_ACTIVATING: begin
        if (i_cfg.quiet || aborting) begin
          state_nxt = das_pkg::DAS_DEACTIVATED;
          sub_nxt = `DAS_SUB_IDLE;
        end else begin
          case (sub_r)
            `DAS_SUB_1: begin
              // Master pre-gain ends at t1; slave waits to t2
              if (inc_r > (master ? t1 : t2)) sub_nxt = `DAS_SUB_2;
            end
            `DAS_SUB_2: begin
              if (master && inc_r > t2) sub_nxt = `DAS_SUB_SIGWAIT;
              if (!master && inc_r > t1) sub_nxt = `DAS_SUB_SIGWAIT;
            end
            `DAS_SUB_SIGWAIT: begin
              // Master holds here until the slave is heard
              if (resync) sub_nxt = `DAS_SUB_4;
              if (!master && inc_r > t3) sub_nxt = `DAS_SUB_4;
            end
            `DAS_SUB_4: begin
              if (inc_r > (master ? t3 : t5)) sub_nxt = `DAS_SUB_5;
            end
            `DAS_SUB_5: begin
              if (inc_r > t4) sub_nxt = `DAS_SUB_6;
            end
            `DAS_SUB_6: begin
              if (master && inc_r > t5) sub_nxt = `DAS_SUB_4LVL;
              if (!master && i_line.s1_det && i_line.train_done) begin
                sub_nxt = framed ? `DAS_SUB_4LVL : `DAS_SUB_IDLE;
                if (!framed) state_nxt = das_pkg::DAS_ACTIVE1;
              end
            end
            `DAS_SUB_4LVL: begin
              if (master && i_line.s1_det && i_line.train_done) begin
                sub_nxt = framed ? `DAS_SUB_FRAME : `DAS_SUB_IDLE;
                if (!framed) state_nxt = das_pkg::DAS_ACTIVE1;
              end
              if (!master && fsw_locked) begin
                state_nxt = das_pkg::DAS_ACTIVE1;
                sub_nxt = `DAS_SUB_IDLE;
              end
            end
            `DAS_SUB_FRAME: begin
              if (fsw_locked) begin
                state_nxt = das_pkg::DAS_ACTIVE1;
                sub_nxt = `DAS_SUB_IDLE;
              end
            end
            default: sub_nxt = `DAS_SUB_IDLE;
          endcase
        end
      end
      das_pkg::DAS_ACTIVE1, das_pkg::DAS_ACTIVE2: begin
        if (i_cfg.quiet) begin
          state_nxt = das_pkg::DAS_DEACTIVATED;
        end else if (framed && fsw_lost) begin
          state_nxt = das_pkg::DAS_PEND_DEACT;
        end else if (framed && mat_exp) begin
          state_nxt = das_pkg::DAS_ACTIVE2;
        end
      end
      das_pkg::DAS_PEND_DEACT: begin
        if (i_cfg.quiet || deact_exp) begin
          state_nxt = das_pkg::DAS_DEACTIVATED;
        end else if (fsw_locked) begin
          state_nxt = mat_exp ? das_pkg::DAS_ACTIVE2 : das_pkg::DAS_ACTIVE1;
        end
      end
      das_pkg::DAS_DEACTIVATED: begin
        // Expired attempt skips the wait; otherwise wait for quiet line
        if (fail_r) begin
          state_nxt = das_pkg::DAS_INACTIVE;
        end else if (master ? los_exp : !i_line.sig_det) begin
          state_nxt = das_pkg::DAS_INACTIVE;
        end
      end
      default: begin
        state_nxt = das_pkg::DAS_INACTIVE;
        sub_nxt = `DAS_SUB_IDLE;
      end
    endcase
  end

  // State and sub-state registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= das_pkg::DAS_INACTIVE;
      sub_r <= `DAS_SUB_IDLE;
    end else begin
      state_r <= state_nxt;
      sub_r <= sub_nxt;
    end
  end

  // Failure mark: expiry during an attempt, cleared once back in Inactive
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fail_r <= 1'b0;
    end else if (state_r == das_pkg::DAS_ACTIVATING && mat_exp) begin
      fail_r <= 1'b1;
    end else if (state_r == das_pkg::DAS_INACTIVE) begin
      fail_r <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Status, transmit choice and data gate all registered
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_stat <= '0;
      o_rx_data <= 1'b1;
    end else begin
      o_stat.state <= state_nxt;
      o_stat.sub <= sub_nxt;
      o_stat.mat_exp <= mat_exp;
      o_stat.active <= state_nxt == das_pkg::DAS_ACTIVE1 ||
                       state_nxt == das_pkg::DAS_ACTIVE2 ||
                       state_nxt == das_pkg::DAS_PEND_DEACT;
      // Data only once receiver training is complete
      o_rx_data <= (state_r == das_pkg::DAS_ACTIVE1 ||
                    state_r == das_pkg::DAS_ACTIVE2 ||
                    state_r == das_pkg::DAS_PEND_DEACT) ? i_rx_data : 1'b1;
      case (state_nxt)
        das_pkg::DAS_ACTIVATING: begin
          if (!master && sub_nxt == `DAS_SUB_1) begin
            o_stat.tx <= das_pkg::DAS_TX_NONE;
          end else if (sub_nxt == `DAS_SUB_FRAME || (sub_nxt == `DAS_SUB_4LVL &&
                       (master || framed))) begin
            o_stat.tx <= das_pkg::DAS_TX_FOUR;
          end else begin
            o_stat.tx <= das_pkg::DAS_TX_TWO;
          end
        end
        das_pkg::DAS_INACTIVE, das_pkg::DAS_DEACTIVATED: begin
          o_stat.tx <= das_pkg::DAS_TX_NONE;
        end
        default: o_stat.tx <= das_pkg::DAS_TX_FOUR;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_master_start;
    master && $past(master) && $rose(state_r == das_pkg::DAS_ACTIVATING)
      |-> $past(i_cfg.act_req) && !$past(i_cfg.quiet);
  endproperty
  a_master_start: assert property (p_master_start)
    else $error("master left idle without request");

  property p_sigwait_hold;
    master && state_r == das_pkg::DAS_ACTIVATING && sub_r == `DAS_SUB_SIGWAIT &&
      !i_line.s0_det && !aborting && !i_cfg.quiet |=> sub_r == `DAS_SUB_SIGWAIT;
  endproperty
  a_sigwait_hold: assert property (p_sigwait_hold)
    else $error("master left signal wait early");

  property p_slave_join;
    !master && state_r == das_pkg::DAS_INACTIVE && i_line.sig_det && !i_cfg.quiet
      |=> state_r == das_pkg::DAS_ACTIVATING && sub_r == `DAS_SUB_1;
  endproperty
  a_slave_join: assert property (p_slave_join)
    else $error("slave did not join");

  property p_slave_silent;
    !master && state_r == das_pkg::DAS_ACTIVATING && sub_r == `DAS_SUB_1
      |-> o_stat.tx == das_pkg::DAS_TX_NONE;
  endproperty
  a_slave_silent: assert property (p_slave_silent)
    else $error("slave transmitting in wait");

  property p_resync;
    resync && !aborting && !i_cfg.quiet |=> inc_r == t2 + 8'd1 && sub_r == `DAS_SUB_4;
  endproperty
  a_resync: assert property (p_resync)
    else $error("resync load wrong");

  property p_unframed_stay;
    !framed && state_r == das_pkg::DAS_ACTIVE1 && !i_cfg.quiet
      |=> state_r == das_pkg::DAS_ACTIVE1;
  endproperty
  a_unframed_stay: assert property (p_unframed_stay)
    else $error("unframed active left");

  property p_active_flag;
    state_r == das_pkg::DAS_ACTIVE1 || state_r == das_pkg::DAS_ACTIVE2 |-> o_stat.active;
  endproperty
  a_active_flag: assert property (p_active_flag)
    else $error("active indicator low");

  property p_abort;
    state_r == das_pkg::DAS_ACTIVATING && mat_exp
      |=> state_r == das_pkg::DAS_DEACTIVATED ##1 state_r == das_pkg::DAS_INACTIVE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("expiry did not abort");

  property p_slave_release;
    !master && state_r == das_pkg::DAS_DEACTIVATED && !i_line.sig_det
      |=> state_r == das_pkg::DAS_INACTIVE;
  endproperty
  a_slave_release: assert property (p_slave_release)
    else $error("slave stuck deactivated");

  property p_rx_held;
    state_r == das_pkg::DAS_ACTIVATING |=> o_rx_data;
  endproperty
  a_rx_held: assert property (p_rx_held)
    else $error("data delivered before active");

  c_active1: cover property (state_r == das_pkg::DAS_ACTIVE1);
  c_active2: cover property (state_r == das_pkg::DAS_ACTIVE2);
  c_pend: cover property (state_r == das_pkg::DAS_PEND_DEACT);
  c_resync: cover property (resync);
endmodule
`default_nettype wire

// file: hdl/das_defines.svh
// Constants of the activation sequencer: timer counts, codes, lengths.
// Assumes a 100 MHz system clock and a line bit enable pulse.
`ifndef DAS_DEFINES_SVH
`define DAS_DEFINES_SVH
// Sub-state timer defaults, in increments
`define DAS_M_SUBSTATE_TIMER_ONE 8'd10
`define DAS_M_SUBSTATE_TIMER_TWO 8'd19
`define DAS_M_SUBSTATE_TIMER_THREE 8'd65
`define DAS_M_SUBSTATE_TIMER_FOUR 8'd78
`define DAS_M_SUBSTATE_TIMER_FIVE 8'd103
`define DAS_S_SUBSTATE_TIMER_ONE 8'd27
`define DAS_S_SUBSTATE_TIMER_TWO 8'd19
`define DAS_S_SUBSTATE_TIMER_THREE 8'd39
`define DAS_S_SUBSTATE_TIMER_FOUR 8'd78
`define DAS_S_SUBSTATE_TIMER_FIVE 8'd64
// Bits per increment: 0.10 s at 784 kbps
`define DAS_INC_BITS 78400
// Frame lengths in bits
`define DAS_FL_STD 26'd4704
`define DAS_FL_M6 26'd7008
`define DAS_MODE6 3'h6
// Multiplier choices for control bits 6:5
`define DAS_ACTIVATION_TIMER_MULTIPLIER_0 26'd5000
`define DAS_ACTIVATION_TIMER_MULTIPLIER_1 26'd2500
`define DAS_ACTIVATION_TIMER_MULTIPLIER_2 26'd1667
// Timer durations in ms and the clock rate
`define DAS_CLK_MHZ 100
`define DAS_DEACT_MS 2000
`define DAS_LOS_MS 1000
// Sync word counts
`define DAS_FSW_LOCK 3'd2
`define DAS_FSW_LOSE 3'd6
// Activating sub-state codes
`define DAS_SUB_IDLE 4'h0
`define DAS_SUB_1 4'h1
`define DAS_SUB_2 4'h2
`define DAS_SUB_SIGWAIT 4'h3
`define DAS_SUB_4 4'h4
`define DAS_SUB_5 4'h5
`define DAS_SUB_6 4'h6
`define DAS_SUB_4LVL 4'h7
`define DAS_SUB_FRAME 4'h8
`endif

// file: hdl/das_pkg.sv
// Types shared by the activation sequencer files.
// Assumes the constants header is included where needed.
`default_nettype none
package das_pkg;
  typedef enum logic [2:0] {
    DAS_INACTIVE, DAS_ACTIVATING, DAS_ACTIVE1,
    DAS_ACTIVE2, DAS_PEND_DEACT, DAS_DEACTIVATED
  } das_state_t;
  typedef enum logic [1:0] {DAS_TX_NONE, DAS_TX_TWO, DAS_TX_FOUR} das_tx_t;
  typedef struct packed {
    logic master;
    logic [2:0] mode;
    logic [1:0] activation_timer_multiplier_sel;
    logic quiet;
    logic act_req;
  } das_cfg_t;
  typedef struct packed {
    logic sig_det;
    logic s0_det;
    logic s1_det;
    logic train_done;
    logic fsw_hit;
  } das_line_t;
  typedef struct packed {
    das_state_t state;
    logic [3:0] sub;
    das_tx_t tx;
    logic active;
    logic mat_exp;
  } das_stat_t;
endpackage
`default_nettype wire

// file: hdl/das_count.sv
// Up-counter that stops at a limit and flags it; also a divider.
// Assumes a single clock and an active-low asynchronous reset.
`default_nettype none
module das_count #(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clr,
  input wire logic i_en,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);
  logic [W-1:0] cnt_r;
  // Count enables, hold at the limit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= '0;
    end else if (i_clr) begin
      cnt_r <= '0;
    end else if (i_en && !o_done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign o_done = (cnt_r >= i_limit);
endmodule
`default_nettype wire

// file: hdl/das_fsw_track.sv
// Frame sync word tracker: lock on two hits, loss on six misses.
// Assumes one frame tick per frame slot and a hit flag at that tick.
`include "das_defines.svh"
`default_nettype none
module das_fsw_track (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_frame_tick,
  input wire logic i_hit,
  output logic o_locked,
  output logic o_lost
);
  logic [2:0] hit_r;
  logic [2:0] miss_r;
  // Consecutive hit and miss runs, reset when idle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hit_r <= '0;
      miss_r <= '0;
    end else if (!i_run) begin
      hit_r <= '0;
      miss_r <= '0;
    end else if (i_frame_tick) begin
      if (i_hit) begin
        miss_r <= '0;
        if (hit_r < `DAS_FSW_LOCK) hit_r <= hit_r + 3'd1;
      end else begin
        hit_r <= '0;
        if (miss_r < `DAS_FSW_LOSE) miss_r <= miss_r + 3'd1;
      end
    end
  end
  assign o_locked = (hit_r == `DAS_FSW_LOCK);
  assign o_lost = (miss_r == `DAS_FSW_LOSE);
endmodule
`default_nettype wire

// file: tb/das_remote.sv
// Behavioural far-end transceiver feeding the sequencer's line inputs.
// Assumes the sequencer's transmit status shows what it puts on the pair.
`default_nettype none
module das_remote #(
  parameter int S1_DLY = 1000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_join,
  input wire logic i_master,
  input wire logic i_fsw_off,
  input wire das_pkg::das_tx_t i_tx,
  output var das_pkg::das_line_t o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Far-end timing
  // ********************
  int cnt;
  logic four;
  // Two-level time heard; stands in for the far master's own timers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
    end else if (!i_join) begin
      cnt <= 0;
    end else if (i_tx == das_pkg::DAS_TX_TWO && cnt < S1_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // Far slave answers our four-level; far master sends it late
  assign four = i_join && (i_master ? (i_tx == das_pkg::DAS_TX_FOUR) : (cnt == S1_DLY));
  // Silent until joined, so both ends start idle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line <= '0;
    end else begin
      o_line.sig_det <= i_join;
      o_line.s0_det <= i_join;
      o_line.s1_det <= four;
      o_line.train_done <= four;
      o_line.fsw_hit <= four && !i_fsw_off;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the activation sequencer with a far-end model.
// Assumes the defines header is on the include path.
`include "das_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEACT = 50;
  localparam int LOSC = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic bit_en = 1'b1;
  logic rx_in = 1'b0;
  logic peer_on = 1'b0;
  logic fsw_off = 1'b0;
  das_pkg::das_cfg_t cfg = '0;
  das_pkg::das_line_t line_in;
  das_pkg::das_stat_t stat;
  logic rx_out;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  always #5 clk = ~clk;
  // Short counts keep the run brief
  // Small multipliers for codes 01 and 10 bring timer expiry into reach
  das_seq #(.INC_BITS(4), .DEACT_CYC(DEACT), .LOS_CYC(LOSC), .ACTIVATION_TIMER_MULTIPLIER_1(26'd3),
    .ACTIVATION_TIMER_MULTIPLIER_2(26'd1)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_bit_en(bit_en), .i_cfg(cfg),
    .i_line(line_in), .i_rx_data(rx_in), .o_stat(stat), .o_rx_data(rx_out)
  );
  das_remote #(.S1_DLY(1000)) u_peer (
    .i_clk(clk), .i_resetn(resetn), .i_join(peer_on), .i_master(cfg.master),
    .i_fsw_off(fsw_off), .i_tx(stat.tx), .o_line(line_in)
  );
  // ********************
  // Helpers
  // ********************
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Kind 0 state, 1 sub-state, 2 transmit; n gives cycles taken
  task automatic wait_for(input int kind, input logic [3:0] v, input int lim);
    logic [3:0] f;
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      f = (kind == 0) ? 4'(stat.state) : (kind == 1) ? stat.sub : 4'(stat.tx);
      if (f === v) begin
        return;
      end
    end
    n_fail++;
    $display("unexpected wait end at %0t: got %h expected %h", $time, f, v);
    results();
  endtask
  // One-cycle request level, dropped long before timer expiry
  task automatic request(input logic [2:0] mode, input logic [1:0] msel);
    cfg = '{master: 1'b1, mode: mode, activation_timer_multiplier_sel: msel, quiet: 1'b0, act_req: 1'b1};
    @(negedge clk);
    chk(stat.state, das_pkg::DAS_ACTIVATING);
    chk(stat.tx, das_pkg::DAS_TX_TWO);
    cfg.act_req = 1'b0;
  endtask
  task automatic hush();
    cfg.quiet = 1'b1;
    wait_for(0, 4'(das_pkg::DAS_DEACTIVATED), 5);
    chk(stat.tx, das_pkg::DAS_TX_NONE);
    cfg.quiet = 1'b0;
  endtask
  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (8) @(negedge clk);
    chk(16'(stat), 16'h0000);
    chk(rx_out, 1'b1);
    resetn = 1'b1;
    // Master unframed, far end joins late
    request(3'h0, 2'b01);
    chk(stat.sub, `DAS_SUB_1);
    wait_for(1, `DAS_SUB_2, 200);
    wait_for(1, `DAS_SUB_SIGWAIT, 300);
    repeat (300) @(negedge clk);
    chk(stat.sub, `DAS_SUB_SIGWAIT);
    chk(rx_out, 1'b1);
    peer_on = 1'b1;
    wait_for(1, `DAS_SUB_4, 5);
    wait_for(1, `DAS_SUB_5, 400);
    chk(n inside {[180:320]}, 1'b1);
    wait_for(1, `DAS_SUB_4LVL, 1000);
    chk(stat.tx, das_pkg::DAS_TX_FOUR);
    wait_for(0, 4'(das_pkg::DAS_ACTIVE1), 5);
    repeat (2) @(negedge clk);
    chk(stat.active, 1'b1);
    chk(rx_out, 1'b0);
    hush();
    peer_on = 1'b0;
    wait_for(0, 4'(das_pkg::DAS_INACTIVE), LOSC + 10);
    // Far end lost in training; a blip restarts the loss timer
    peer_on = 1'b1;
    request(3'h0, 2'b10);
    wait_for(1, `DAS_SUB_4, 400);
    peer_on = 1'b0;
    wait_for(0, 4'(das_pkg::DAS_DEACTIVATED), 5);
    chk(stat.tx, das_pkg::DAS_TX_NONE);
    repeat (LOSC - 5) @(negedge clk);
    peer_on = 1'b1;
    @(negedge clk);
    peer_on = 1'b0;
    wait_for(0, 4'(das_pkg::DAS_INACTIVE), LOSC + 10);
    chk(n >= LOSC - 2, 1'b1);
    // No far end: expiry after one frame's worth of bits, no loss wait
    request(3'h0, 2'b10);
    wait_for(0, 4'(das_pkg::DAS_DEACTIVATED), 5000);
    chk(n inside {[4700:4708]}, 1'b1);
    chk(stat.tx, das_pkg::DAS_TX_NONE);
    wait_for(0, 4'(das_pkg::DAS_INACTIVE), 3);
    chk(n == 0, 1'b1);
    // Slave unframed answering a far master
    cfg = '{master: 1'b0, mode: 3'h4, activation_timer_multiplier_sel: 2'b11, quiet: 1'b0, act_req: 1'b0};
    peer_on = 1'b1;
    wait_for(0, 4'(das_pkg::DAS_ACTIVATING), 5);
    chk(stat.sub, `DAS_SUB_1);
    chk(stat.tx, das_pkg::DAS_TX_NONE);
    wait_for(2, 4'(das_pkg::DAS_TX_TWO), 400);
    chk(stat.sub, `DAS_SUB_2);
    chk(n > 80, 1'b1);
    wait_for(0, 4'(das_pkg::DAS_ACTIVE1), 1500);
    chk(stat.tx, das_pkg::DAS_TX_FOUR);
    hush();
    peer_on = 1'b0;
    wait_for(0, 4'(das_pkg::DAS_INACTIVE), 5);
    // Master framed: sync word search, then loss of sync
    peer_on = 1'b1;
    request(3'h6, 2'b01);
    wait_for(1, `DAS_SUB_FRAME, 2000);
    chk(rx_out, 1'b1);
    wait_for(0, 4'(das_pkg::DAS_ACTIVE1), 15000);
    chk(n >= 7000, 1'b1);
    wait_for(0, 4'(das_pkg::DAS_ACTIVE2), 15000);
    chk(stat.active, 1'b1);
    chk(rx_out, 1'b0);
    fsw_off = 1'b1;
    wait_for(0, 4'(das_pkg::DAS_PEND_DEACT), 50000);
    chk(n > 35000, 1'b1);
    wait_for(0, 4'(das_pkg::DAS_DEACTIVATED), DEACT + 10);
    chk(n >= DEACT - 2, 1'b1);
    results();
  end
endmodule
`default_nettype wire
